// File: core/vectored_irq_controller_init.v
// Vectored interrupt controller: init words, mask and acknowledge vectors
// Overview of operation
// - CALL, interval 4: byte two is A7..A5, level, then 00.
// - CALL, interval 8: byte two is A7..A6, level, then 000.
// - CALL third acknowledge drives the upper address byte from word two.
// - Vector-pointer mode uses two acknowledges and never sends the CALL opcode.
// - Pointer mode first acknowledge freezes requests, bus off, master drives cascade.
// - Pointer mode second acknowledge drives T7..T3 and the level.
// - Write with address low and bit 4 high starts initialization.
// - Host writes two to four init words, then mask words anytime.
// - Init start resets edge sensing; new rising edge needed afterwards.
// - Init start clears masks, special mask mode, selects pending register reads.
// - Init start makes input 7 lowest priority and slave address 7.
// - Without fourth word, buffered, auto end and pointer mode clear.
// - Level trigger bit makes requests level sensitive, no edge detect.
// - Interval bit selects spacing four when set, eight when clear.
// - Single device bit skips the third init word.
// - Fourth-word bit set means a fourth init word is accepted.
// - Master: slave bits in word three; slave supplies later vector bytes.
// - Slave: identity from word three bits 2..0; drives on cascade match.
// - Buffered mode turns slave pin into enable; master bit chooses role.
// - Special nesting bit selects special fully nested mode.
// - Auto end bit selects automatic end of interrupt mode.
// - Processor mode bit: zero three-byte CALL, one two-cycle pointer.
// - CALL mode first acknowledge drives opcode 11001101.
// - Mask bit one inhibits its channel, zero enables it.
`timescale 1ns/1ps
`include "vic_defines.vh"
module vectored_irq_controller_init (
	input wire core_clk,
	input wire rst_n,
	input wire chip_select_n,
	input wire write_n,
	input wire read_n,
	input wire addr_select,
	input wire [7:0] data_in,
	input wire interrupt_acknowledge_n,
	input wire [7:0] request_input,
	input wire [2:0] cascade_in,
	input wire slave_program_in,
	output reg [7:0] data_out,
	output reg data_oe_n,
	output reg [2:0] cascade_out,
	output reg cascade_oe_n,
	output reg slave_program_buffer_enable,
	output reg buffer_mode_active,
	output reg interrupt_out,
	output reg special_nesting_enable,
	output reg auto_end_of_interrupt,
	output reg special_mask_mode,
	output reg status_read_pending,
	output reg [2:0] lowest_priority_level,
	output reg init_done
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_W2 = 4'b0010;
	localparam ST_W3 = 4'b0100;
	localparam ST_W4 = 4'b1000;

	reg [3:0] initState;
	reg [7:0] wordOne;
	reg [7:0] vectorBase;
	reg [7:0] cascadeWord;
	reg [7:0] optionsWord;
	reg [7:0] mask_bits;
	reg [2:0] slaveId;

	// Pin synchronisers
	reg [3:0] ctlSyncA;
	reg [3:0] ctlSyncB;
	reg [7:0] dataSyncA;
	reg [7:0] dataSyncB;
	reg addrSyncA;
	reg addrSyncB;
	reg [2:0] casSyncA;
	reg [2:0] casSyncB;
	reg spSyncA;
	reg spSyncB;
	reg wrPrev;
	reg ackPrev;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctlSyncA <= 4'hf;
			ctlSyncB <= 4'hf;
			dataSyncA <= 8'h00;
			dataSyncB <= 8'h00;
			addrSyncA <= 1'b0;
			addrSyncB <= 1'b0;
			casSyncA <= 3'h0;
			casSyncB <= 3'h0;
			spSyncA <= 1'b1;
			spSyncB <= 1'b1;
			wrPrev <= 1'b1;
			ackPrev <= 1'b1;
		end else begin
			ctlSyncA <= {chip_select_n, write_n, read_n,
				interrupt_acknowledge_n};
			ctlSyncB <= ctlSyncA;
			dataSyncA <= data_in;
			dataSyncB <= dataSyncA;
			addrSyncA <= addr_select;
			addrSyncB <= addrSyncA;
			casSyncA <= cascade_in;
			casSyncB <= casSyncA;
			spSyncA <= slave_program_in;
			spSyncB <= spSyncA;
			wrPrev <= ctlSyncB[3] | ctlSyncB[2];
			ackPrev <= ctlSyncB[0];
		end
	end

	wire wrActive = ~ctlSyncB[3] & ~ctlSyncB[2];
	// Write taken on trailing edge of the strobe, data still held
	wire wrStrobe = ~wrActive & ~wrPrev;
	reg [7:0] wrData;
	reg wrAddr;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrData <= 8'h00;
			wrAddr <= 1'b0;
		end else if (wrActive) begin
			wrData <= dataSyncB;
			wrAddr <= addrSyncB;
		end
	end
	wire ackStart = ackPrev & ~ctlSyncB[0];
	wire ackEnd = ~ackPrev & ctlSyncB[0];

	wire initStart = wrStrobe & ~wrAddr & wrData[`W1_SELECT];
	wire levelMode = wordOne[`W1_LEVEL];
	wire interval4 = wordOne[`W1_INTERVAL];
	wire bufMode = optionsWord[`W4_BUFFERED];
	wire pointerMode = optionsWord[`W4_PMODE];
	// Role from master bit only when buffered, else from pin
	wire isMaster = bufMode ? optionsWord[`W4_MASTER] : spSyncB;
	wire singleDev = wordOne[`W1_SINGLE];

	// Initialization sequencing
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			initState <= ST_IDLE;
			wordOne <= 8'h00;
			vectorBase <= 8'h00;
			cascadeWord <= 8'h00;
			optionsWord <= 8'h00;
			slaveId <= `SLAVE_ID_RESET;
			init_done <= 1'b0;
		end else if (initStart) begin
			wordOne <= wrData;
			slaveId <= `SLAVE_ID_RESET;
			if (!wrData[`W1_NEED4])
				optionsWord <= 8'h00;
			init_done <= 1'b0;
			initState <= ST_W2;
		end else if (wrStrobe && wrAddr) begin
			case (initState)
			ST_W2: begin
				vectorBase <= wrData;
				if (!singleDev)
					initState <= ST_W3;
				else if (wordOne[`W1_NEED4])
					initState <= ST_W4;
				else begin
					initState <= ST_IDLE;
					init_done <= 1'b1;
				end
			end
			ST_W3: begin
				cascadeWord <= wrData;
				slaveId <= wrData[2:0];
				if (wordOne[`W1_NEED4]) begin
					initState <= ST_W4;
				end else begin
					initState <= ST_IDLE;
					init_done <= 1'b1;
				end
			end
			ST_W4: begin
				optionsWord <= wrData;
				initState <= ST_IDLE;
				init_done <= 1'b1;
			end
			ST_IDLE: begin
				initState <= ST_IDLE;
			end
			default: begin
				initState <= ST_IDLE;
			end
			endcase
		end
	end

	// Mask word: A0 high write after init
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_bits <= 8'h00;
			special_mask_mode <= 1'b0;
			status_read_pending <= 1'b1;
			lowest_priority_level <= `DEFAULT_LEVEL;
		end else if (initStart) begin
			mask_bits <= 8'h00;
			special_mask_mode <= 1'b0;
			status_read_pending <= 1'b1;
			lowest_priority_level <= `DEFAULT_LEVEL;
		end else if (wrStrobe && wrAddr && initState == ST_IDLE
			&& init_done) begin
			mask_bits <= wrData;
		end
	end

	// Request capture, one latch per input
	wire [7:0] pending_request_register;
	reg [7:0] clearPend;
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : chan
			request_latch u_latch (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.reqIn(request_input[g]),
				.levelMode(levelMode),
				.initStart(initStart),
				.clearPend(clearPend[g]),
				.pending(pending_request_register[g])
			);
		end
	endgenerate

	wire [7:0] active = pending_request_register & ~mask_bits;
	reg [2:0] bestLevel;
	reg anyActive;
	integer i;
	always @* begin
		bestLevel = `DEFAULT_LEVEL;
		anyActive = 1'b0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (active[i]) begin
				bestLevel = i[2:0];
				anyActive = 1'b1;
			end
		end
	end

	// Acknowledge sequencing
	reg [1:0] ackCount;
	reg [2:0] frozenLevel;
	reg levelIsSlave;
	wire lastAck = pointerMode ? (ackCount == 2'd1) : (ackCount == 2'd2);
	wire driveLater = isMaster ? ~levelIsSlave
		: (casSyncB == slaveId);
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ackCount <= 2'd0;
			frozenLevel <= `DEFAULT_LEVEL;
			levelIsSlave <= 1'b0;
			clearPend <= 8'h00;
			data_out <= 8'h00;
			data_oe_n <= 1'b1;
			cascade_out <= 3'h0;
			cascade_oe_n <= 1'b1;
			interrupt_out <= 1'b0;
		end else begin
			clearPend <= 8'h00;
			interrupt_out <= anyActive & init_done & ackCount == 2'd0;
			if (ackStart) begin
				data_oe_n <= 1'b1;
				if (ackCount == 2'd0) begin
					// Freeze resolved level on the first pulse
					frozenLevel <= bestLevel;
					levelIsSlave <= isMaster & ~singleDev
						& cascadeWord[bestLevel];
					if (anyActive)
						clearPend[bestLevel] <= 1'b1;
					if (!pointerMode) begin
						data_out <= `CALL_OPCODE;
						data_oe_n <= ~isMaster & ~singleDev;
					end else begin
						data_oe_n <= 1'b1;
					end
				end else if (pointerMode) begin
					data_out <= {vectorBase[7:3], frozenLevel};
					data_oe_n <= ~driveLater;
				end else if (ackCount == 2'd1) begin
					if (interval4)
						data_out <= {wordOne[7:5], frozenLevel,
							2'b00};
					else
						data_out <= {wordOne[7:6], frozenLevel,
							3'b000};
					data_oe_n <= ~driveLater;
				end else begin
					data_out <= vectorBase;
					data_oe_n <= ~driveLater;
				end
			end else if (ackEnd) begin
				data_oe_n <= 1'b1;
				if (ackCount == 2'd0 && isMaster && levelIsSlave) begin
					cascade_out <= frozenLevel;
					cascade_oe_n <= 1'b0;
				end
				if (lastAck) begin
					ackCount <= 2'd0;
					cascade_oe_n <= 1'b1;
				end else begin
					ackCount <= ackCount + 2'd1;
				end
			end
		end
	end

	// Mode outputs
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			special_nesting_enable <= 1'b0;
			auto_end_of_interrupt <= 1'b0;
			buffer_mode_active <= 1'b0;
			slave_program_buffer_enable <= 1'b1;
		end else begin
			special_nesting_enable <= optionsWord[`W4_NESTING];
			auto_end_of_interrupt <= optionsWord[`W4_AUTOEOI];
			buffer_mode_active <= bufMode;
			slave_program_buffer_enable <= ~(bufMode & ~data_oe_n);
		end
	end
endmodule

// File: core/vic_defines.vh
// Constants for the vectored interrupt controller
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH
`define CALL_OPCODE 8'hcd
`define W1_LEVEL 3
`define W1_INTERVAL 2
`define W1_SINGLE 1
`define W1_NEED4 0
`define W1_SELECT 4
`define W4_NESTING 4
`define W4_BUFFERED 3
`define W4_MASTER 2
`define W4_AUTOEOI 1
`define W4_PMODE 0
`define SLAVE_ID_RESET 3'h7
`define DEFAULT_LEVEL 3'h7
`endif

// File: core/request_latch.v
// Request capture for one input: edge or level sense
`timescale 1ns/1ps
module request_latch (
	input wire core_clk,
	input wire rst_n,
	input wire reqIn,
	input wire levelMode,
	input wire initStart,
	input wire clearPend,
	output reg pending
);
	reg syncA;
	reg syncB;
	reg prevReq;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			prevReq <= 1'b1;
			pending <= 1'b0;
		end else begin
			syncA <= reqIn;
			syncB <= syncA;
			// Start of init forces a fresh rising edge
			prevReq <= initStart ? 1'b1 : syncB;
			if (initStart)
				pending <= 1'b0;
			else if (levelMode)
				pending <= syncB;
			else if (syncB && !prevReq)
				pending <= 1'b1;
			else if (clearPend)
				pending <= 1'b0;
		end
	end
endmodule

// File: test/irq_ctrl_monitor.sv
// Port checker for the vectored interrupt controller
`timescale 1ns/1ps
module irq_ctrl_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic write_n,
	input wire logic addr_select,
	input wire logic [7:0] data_in,
	input wire logic interrupt_acknowledge_n,
	input wire logic data_oe_n,
	input wire logic slave_program_buffer_enable,
	input wire logic buffer_mode_active,
	input wire logic interrupt_out,
	input wire logic special_mask_mode,
	input wire logic status_read_pending,
	input wire logic [2:0] lowest_priority_level,
	input wire logic init_done
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_smm; !special_mask_mode; endproperty
	a_smm: assert property (p_smm) else $error("mask mode set");
	property p_stat; status_read_pending; endproperty
	a_stat: assert property (p_stat) else $error("status target");
	property p_lvl; lowest_priority_level == 3'h7; endproperty
	a_lvl: assert property (p_lvl) else $error("lowest level");
	property p_init;
		($rose(write_n) && !chip_select_n && !addr_select && data_in[4])
			|-> ##[1:6] !init_done;
	endproperty
	a_init: assert property (p_init) else $error("no restart");
	property p_intr; !init_done ##1 !init_done |-> !interrupt_out; endproperty
	a_intr: assert property (p_intr) else $error("early int");
	property p_bufOff; !buffer_mode_active |-> slave_program_buffer_enable;
	endproperty
	a_bufOff: assert property (p_bufOff) else $error("enable pin");
	property p_bufOn;
		buffer_mode_active && !data_oe_n ##1 !data_oe_n
			|-> !slave_program_buffer_enable;
	endproperty
	a_bufOn: assert property (p_bufOn) else $error("enable idle");
	property p_oeIdle; interrupt_acknowledge_n [*6] |-> data_oe_n; endproperty
	a_oeIdle: assert property (p_oeIdle) else $error("bus driven");
	property p_first; $fell(interrupt_acknowledge_n) |-> data_oe_n [*2];
	endproperty
	a_first: assert property (p_first) else $error("early drive");
	property p_rel; $rose(interrupt_acknowledge_n) |-> ##[1:5] data_oe_n;
	endproperty
	a_rel: assert property (p_rel) else $error("no release");
endmodule
bind vectored_irq_controller_init irq_ctrl_monitor u_mon (.*);

// File: test/host_cpu_model.sv
// Host processor model: command writes and acknowledge pulses
`timescale 1ns/1ps
module host_cpu_model (
	input wire logic core_clk,
	output logic chip_select_n,
	output logic write_n,
	output logic addr_select,
	output logic [7:0] data_in,
	output logic interrupt_acknowledge_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n
);
	initial begin
		chip_select_n = 1;
		write_n = 1;
		addr_select = 0;
		data_in = 8'h00;
		interrupt_acknowledge_n = 1;
	end
	task wr(input logic a, input logic [7:0] v);
		@(posedge core_clk);
		#1 chip_select_n = 0;
		write_n = 0;
		addr_select = a;
		data_in = v;
		repeat (4) @(posedge core_clk);
		#1 write_n = 1;
		@(posedge core_clk);
		#1 chip_select_n = 1;
		addr_select = ~a;
		data_in = ~v;
		repeat (8) @(posedge core_clk);
		#1;
	endtask
	task ack(output logic [7:0] v, output logic oe);
		@(posedge core_clk);
		#1 interrupt_acknowledge_n = 0;
		repeat (5) @(posedge core_clk);
		#1 v = data_out;
		oe = data_oe_n;
		interrupt_acknowledge_n = 1;
		repeat (6) @(posedge core_clk);
		#1;
	endtask
endmodule

// File: test/testbench.sv
// Directed bench for init sequences and acknowledge vectors
`timescale 1ns/1ps
module testbench;
	logic core_clk, rst_n, read_n, chip_select_n, write_n, addr_select;
	logic interrupt_acknowledge_n, slave_program_in, data_oe_n;
	logic cascade_oe_n, slave_program_buffer_enable, buffer_mode_active;
	logic interrupt_out, special_nesting_enable, auto_end_of_interrupt;
	logic special_mask_mode, status_read_pending, init_done, oe;
	logic [7:0] data_in, request_input, data_out, d;
	logic [2:0] cascade_in, cascade_out, lowest_priority_level;
	int n_mismatch = 0;
	int checks_done = 0;
	vectored_irq_controller_init u_dut (.*);
	host_cpu_model u_host (.*);
	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task w6;
		repeat (6) @(posedge core_clk);
		#1;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		rst_n = 0;
		read_n = 1;
		slave_program_in = 1;
		cascade_in = 3'h0;
		request_input = 8'h40;
		repeat (10) @(posedge core_clk);
		#1 rst_n = 1;
		w6;
		chk(status_read_pending, 1);
		chk(lowest_priority_level, 3'h7);
		chk(init_done, 0);
		// Pointer mode, buffered master, level sense, all word-four options on
		u_host.wr(0, 8'h1b);
		u_host.wr(1, 8'ha8);
		chk(init_done, 0);
		u_host.wr(1, 8'h1f);
		chk(init_done, 1);
		chk(special_nesting_enable, 1);
		chk(auto_end_of_interrupt, 1);
		chk(buffer_mode_active, 1);
		chk(interrupt_out, 1);
		u_host.ack(d, oe);
		chk(oe, 1);
		u_host.ack(d, oe);
		chk(d, 8'hae);
		// Cascaded slave, identity 2
		slave_program_in = 0;
		cascade_in = 3'h2;
		request_input = 8'h00;
		u_host.wr(0, 8'h11);
		u_host.wr(1, 8'h48);
		chk(init_done, 0);
		u_host.wr(1, 8'h02);
		u_host.wr(1, 8'h01);
		chk(init_done, 1);
		request_input = 8'h02;
		w6;
		u_host.ack(d, oe);
		u_host.ack(d, oe);
		chk(d, 8'h49);
		chk(oe, 0);
		cascade_in = 3'h5;
		request_input = 8'h04;
		w6;
		u_host.ack(d, oe);
		u_host.ack(d, oe);
		chk(oe, 1);
		// Three-byte sequence, interval four, mask check
		slave_program_in = 1;
		request_input = 8'h00;
		u_host.wr(0, 8'hb6);
		u_host.wr(1, 8'h3c);
		chk(auto_end_of_interrupt, 0);
		chk(buffer_mode_active, 0);
		u_host.wr(1, 8'h20);
		request_input = 8'h20;
		w6;
		chk(interrupt_out, 0);
		u_host.wr(1, 8'h00);
		chk(interrupt_out, 1);
		u_host.ack(d, oe);
		chk(d, 8'hcd);
		u_host.ack(d, oe);
		chk(d, 8'hb4);
		u_host.ack(d, oe);
		chk(d, 8'h3c);
		// Interval eight; held input needs a new edge
		u_host.wr(0, 8'hb2);
		u_host.wr(1, 8'h3c);
		w6;
		chk(interrupt_out, 0);
		request_input = 8'h08;
		w6;
		u_host.ack(d, oe);
		chk(d, 8'hcd);
		u_host.ack(d, oe);
		chk(d, 8'h98);
		u_host.ack(d, oe);
		chk(d, 8'h3c);
		// Cascaded master, slave on level 3, pointer mode
		request_input = 8'h00;
		u_host.wr(0, 8'h11);
		u_host.wr(1, 8'h48);
		u_host.wr(1, 8'h08);
		u_host.wr(1, 8'h01);
		request_input = 8'h08;
		w6;
		u_host.ack(d, oe);
		chk(oe, 1);
		chk(cascade_out, 3'h3);
		chk(cascade_oe_n, 0);
		u_host.ack(d, oe);
		chk(oe, 1);
		chk(cascade_oe_n, 1);
		report_and_stop;
	end
endmodule
